// File: dv/rxd_host_model.sv
// ahb-lite master standing in for the host
`timescale 1ns/1ns
module rxd_host_model
(
    input  wire logic        clock,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    import rxd_pkg::*;
    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end
    // single word transfer at index times four
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    begin
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hwdata <= ~hwdata;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        rd = hrdata;
    end
    endtask
endmodule

// File: dv/rxd_properties.sv
// concurrent checks for the receive decoder configuration registers
`timescale 1ns/1ns
module rxd_properties
(
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic              sample_valid,
    input wire logic [3:0]        sig_strength,
    input wire logic [7:0]        half_strong,
    input wire logic [7:0]        half_weak,
    input wire logic [7:0]        i_amp,
    input wire logic [7:0]        q_amp,
    input wire logic              comm_active,
    input wire logic              receiving,
    input wire rxd_pkg::rxd_bit_t rx_in,
    input wire logic              sig_accepted,
    input wire logic              bit_collision,
    input wire logic              use_q_channel,
    input wire logic [1:0]        pll_time_constant,
    input wire logic              pll_frozen,
    input wire logic [3:0]        extra_response_bits,
    input wire logic              tx_parity_enable,
    input wire rxd_pkg::rxd_bit_t rx_out,
    input wire logic              rx_parity_error
);
    import rxd_pkg::*;
    logic       wp;
    logic [7:0] wi;
    logic [7:0] thr;
    logic [7:0] dmd;
    logic [1:0] txw;
    logic       poff;
    // shadow of the host writes
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wp   <= 1'b0;
            wi   <= 8'h00;
            thr  <= RST_THRESHOLD;
            dmd  <= RST_DEMOD;
            txw  <= RST_TX_TIMING[1:0];
            poff <= 1'b0;
        end
        else if (hready)
        begin
            wp <= hsel && htrans == HTRANS_NONSEQ && hwrite;
            wi <= haddr[9:2];
            if (wp && wi == IDX_THRESHOLD) thr <= hwdata[7:0] & WMASK_THRESHOLD;
            if (wp && wi == IDX_DEMOD) dmd <= hwdata[7:0];
            if (wp && wi == IDX_TX_TIMING) txw <= hwdata[1:0];
            if (wp && wi == IDX_RX_PARITY) poff <= hwdata[PAR_OFF_BIT];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_bus_okay: assert property (!$past(rst) |-> hreadyout && !hresp)
        else $error("bus not ready or error response");
    a_min_level: assert property (sample_valid |=> sig_accepted == ($past(sig_strength) >= $past(thr[7:4])))
        else $error("signal acceptance wrong");
    a_coll_level: assert property (sample_valid |=> bit_collision == (sig_accepted
        && {$past(half_weak), 3'h0} >= 11'($past(half_strong)) * 11'($past(thr[2:0]))))
        else $error("collision flag wrong");
    a_stronger_chan: assert property (!dmd[5] && dmd[7:6] == CH_STRONGER |=> use_q_channel == $past(q_amp > i_amp))
        else $error("stronger channel not chosen");
    a_frozen_chan: assert property (!dmd[5] && dmd[7:6] == CH_FROZEN && comm_active && $past(comm_active)
        |=> $stable(use_q_channel))
        else $error("channel moved during communication");
    a_fixed_chan: assert property (dmd[5] |=> use_q_channel == $past(dmd[6]))
        else $error("fixed channel wrong");
    a_extra_resp: assert property (!$past(rst) |-> extra_response_bits == {2'h0, $past(txw)} + TX_WAIT_OFFSET)
        else $error("response time wrong");
    a_tx_parity: assert property (!$past(rst) |-> tx_parity_enable == !$past(poff))
        else $error("transmit parity enable wrong");
    a_pll_select: assert property (!$past(rst) |-> pll_time_constant ==
        ($past(receiving) ? $past(dmd[3:2]) : $past(dmd[1:0])))
        else $error("pll constant wrong");
    a_pll_freeze: assert property (!$past(rst) |-> pll_frozen == ($past(receiving) && $past(dmd[3:2]) == 2'h0))
        else $error("pll freeze wrong");
    a_parity_pass: assert property (poff && rx_in.valid |=> rx_out.valid && rx_out.data == $past(rx_in.data)
        && !rx_parity_error)
        else $error("bit not passed as data");
    c_collision: cover property (sample_valid ##1 bit_collision);
    c_frozen: cover property (!dmd[5] && dmd[7:6] == CH_FROZEN && comm_active [*3]);
    c_parity_err: cover property (rx_parity_error);
endmodule

// File: dv/testbench.sv
// self-checking bench for the receive decoder configuration registers
`timescale 1ns/1ns
module testbench;
    import rxd_pkg::*;
    logic        clock, rst, hsel, hwrite, hready, hreadyout, hresp, sig_accepted, bit_collision;
    logic        use_q_channel, timer_tick, pll_frozen, tx_parity_enable, rx_parity_error;
    logic        carrier_tick = 1'b0, sample_valid = 1'b0, comm_active = 1'b0, receiving = 1'b0;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, pll_time_constant;
    logic [2:0]  hsize;
    logic [3:0]  sig_strength = 4'h0, extra_response_bits;
    logic [7:0]  half_strong = 8'h00, half_weak = 8'h00, i_amp = 8'h00, q_amp = 8'h00;
    logic [11:0] timer_divider_value = 12'h003;
    rxd_bit_t    rx_in = '0, rx_out;
    int          err_total = 0, n_tests = 0;
    assign hready = hreadyout;
    rxd_config_regs dut (.*);
    rxd_host_model host (.clock, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) carrier_tick <= ~carrier_tick;
    task automatic summarize;
    begin
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host.xfer(1'b1, idx, {24'h0, d}, rd);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    begin
        host.xfer(1'b0, idx, 32'h0, rd);
        chk(rd, {24'h0, exp});
    end
    endtask
    task automatic t_regs;
        logic [7:0] ix [7] = '{IDX_THRESHOLD, IDX_DEMOD, IDX_RSVD_A, IDX_RSVD_B, IDX_TX_TIMING, IDX_RX_PARITY, 8'h1e};
        logic [7:0] ev [3][7] = '{'{8'h84, 8'h4d, 8'h00, 8'h00, 8'h62, 8'h00, 8'h00},
                                 '{8'hf7, 8'hff, 8'h00, 8'h00, 8'h63, 8'h10, 8'h00},
                                 '{8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00}};
        logic [3:0] er [3] = '{4'h9, 4'ha, 4'h7};
    begin
        for (int p = 0; p < 3; p++)
        begin
            for (int i = 0; i < 7 && p > 0; i++) wr(ix[i], p == 1 ? 8'hff : 8'h00);
            for (int i = 0; i < 7; i++) rdc(ix[i], ev[p][i]);
            chk(extra_response_bits, er[p]);
            chk(tx_parity_enable, p != 1);
        end
    end
    endtask
    task automatic smp(input logic [3:0] s, input logic [7:0] st, input logic [7:0] wk, input logic [1:0] ex);
    begin
        @(posedge clock);
        sample_valid <= 1'b1;
        sig_strength <= s;
        half_strong  <= st;
        half_weak    <= wk;
        @(posedge clock);
        sample_valid <= 1'b0;
        @(negedge clock);
        chk({sig_accepted, bit_collision}, ex);
    end
    endtask
    task automatic chan(input logic [7:0] dm, input logic [7:0] ia, input logic [7:0] qa, input logic ex);
    begin
        wr(IDX_DEMOD, dm);
        i_amp <= ia;
        q_amp <= qa;
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk(use_q_channel, ex);
    end
    endtask
    task automatic tmr(input logic [7:0] dm, input logic [11:0] dv, input int per);
        int n;
    begin
        wr(IDX_DEMOD, dm);
        timer_divider_value <= dv;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do
            begin
                @(negedge clock);
                n++;
            end while (timer_tick !== 1'b1 && n < 60);
        end
        chk(n, per);
    end
    endtask
    task automatic pll(input logic [7:0] dm, input logic rc, input logic [2:0] ex);
    begin
        wr(IDX_DEMOD, dm);
        receiving <= rc;
        repeat (2) @(negedge clock);
        chk({pll_frozen, pll_time_constant}, ex);
    end
    endtask
    task automatic rxb(input logic d, input logic p, input logic [2:0] ex);
    begin
        @(posedge clock);
        rx_in <= {1'b1, d, p};
        @(posedge clock);
        rx_in <= '0;
        @(negedge clock);
        chk({rx_out.valid, rx_out.data, rx_parity_error}, ex);
    end
    endtask
    initial
    begin
        rst = 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        $display("register map done");
        wr(IDX_THRESHOLD, 8'h53);
        smp(4'h4, 8'h50, 8'h1e, 2'b00);
        smp(4'h5, 8'h50, 8'h1e, 2'b11);
        smp(4'h5, 8'h50, 8'h1d, 2'b10);
        $display("decoder thresholds done");
        for (int c = 0; c < 4; c++) chan(8'h20 | 8'(c << 6), 8'h20, 8'h10, c[0]);
        chan(8'h00, 8'h10, 8'h20, 1'b1);
        chan(8'h00, 8'h20, 8'h10, 1'b0);
        chan(8'h80, 8'h10, 8'h20, 1'b0);
        chan(8'hc0, 8'h10, 8'h20, 1'b0);
        chan(8'h40, 8'h10, 8'h20, 1'b1);
        @(posedge clock);
        comm_active <= 1'b1;
        repeat (3) @(posedge clock);
        chan(8'h40, 8'h20, 8'h10, 1'b1);
        @(posedge clock);
        comm_active <= 1'b0;
        $display("channel select done");
        tmr(8'h4d, 12'h003, 14);
        tmr(8'h5d, 12'h003, 16);
        tmr(8'h4d, 12'h000, 2);
        tmr(8'h5d, 12'h000, 4);
        $display("timer prescale done");
        pll(8'h4d, 1'b1, 3'b011);
        pll(8'h4d, 1'b0, 3'b001);
        pll(8'h41, 1'b1, 3'b100);
        pll(8'h41, 1'b0, 3'b001);
        $display("pll constants done");
        rxb(1'b1, 1'b0, 3'b110);
        rxb(1'b0, 1'b0, 3'b100);
        rxb(1'b1, 1'b0, 3'b110);
        rxb(1'b0, 1'b1, 3'b001);
        rxb(1'b1, 1'b0, 3'b110);
        rxb(1'b0, 1'b1, 3'b000);
        wr(IDX_RX_PARITY, 8'h10);
        rxb(1'b1, 1'b1, 3'b110);
        rxb(1'b0, 1'b1, 3'b100);
        $display("parity handling done");
        summarize();
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        summarize();
    end
endmodule
bind rxd_config_regs rxd_properties u_props (.*);

// File: rtl/rxd_config_regs.sv
// receive decoder configuration registers with their decoder, channel, timer and parity logic
//
// Summary of operation
// [RL1] decoder ignores signal below the four-bit minimum level in bits 7..4
// [RL2] collision flagged only when weak half-bit reaches threshold relative to strong
// [RL3] mode 00 picks stronger channel; 01 picks and freezes it; 10, 11 reserved
// [RL4] automatic channel modes act only while fixed-channel bit 5 is zero
// [RL5] fixed-channel bit set: low mode bit 0 uses I, 1 uses Q
// [RL6] even-prescale zero: timer tick every 2*divider+1 carrier cycles
// [RL7] even-prescale one: timer tick every 2*divider+2 carrier cycles
// [RL8] receive time constant drives pll during reception; 00 freezes it
// [RL9] burst time constant in bits 1..0 drives pll during burst
// [RL10] extra response time is transmit-wait field plus seven bit periods
// [RL11] parity-off bit 4 stops transmit parity and receive parity check
// [RL12] with parity off the received parity bit passes on as data
// [RL13] threshold register resets to 84h
// [RL14] transmit timing register resets to 62h
// [RL15] reserved slots 1Ah and 1Bh reset to 00h
// [RL16] reserved bits and registers read zero, writes have no effect; transmit timing bits 7..2 keep their reset bits and read back as 60h
// [RL17] host changes settings only while no transfer is in progress
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ns
module rxd_config_regs
#(
    parameter int TDIV_W = 12
)
(
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                carrier_tick,
    input  wire logic [TDIV_W-1:0]   timer_divider_value,
    input  wire logic                sample_valid,
    input  wire logic [3:0]          sig_strength,
    input  wire logic [7:0]          half_strong,
    input  wire logic [7:0]          half_weak,
    input  wire logic [7:0]          i_amp,
    input  wire logic [7:0]          q_amp,
    input  wire logic                comm_active,
    input  wire logic                receiving,
    input  wire rxd_pkg::rxd_bit_t   rx_in,
    output logic                     sig_accepted,
    output logic                     bit_collision,
    output logic                     use_q_channel,
    output logic                     timer_tick,
    output logic [1:0]               pll_time_constant,
    output logic                     pll_frozen,
    output logic [3:0]               extra_response_bits,
    output logic                     tx_parity_enable,
    output rxd_pkg::rxd_bit_t        rx_out,
    output logic                     rx_parity_error
);
    import rxd_pkg::*;

    if (TDIV_W < 1 || TDIV_W > 16)
    begin : g_chk
        $error("TDIV_W must be 1 to 16");
    end

    localparam int TCNT_W = TDIV_W + 2;

    // index decode from byte address
    function automatic logic [7:0] reg_index(input logic [31:0] a);
        reg_index = a[ADDR_SHIFT+7:ADDR_SHIFT];
    endfunction

    function automatic logic idx_hit(input logic [31:0] a);
        logic [7:0] i;
        i = reg_index(a);
        idx_hit = (a[31:ADDR_SHIFT+8] == '0) && (a[ADDR_SHIFT-1:0] == '0)
                  && (i >= IDX_THRESHOLD) && (i <= IDX_RX_PARITY);
    endfunction

    // register state
    logic [7:0]   threshold_reg;
    logic [7:0]   threshold_next;
    logic [7:0]   demod_reg;
    logic [7:0]   demod_next;
    logic [7:0]   tx_timing_reg;
    logic [7:0]   tx_timing_next;
    logic [7:0]   rx_parity_reg;
    logic [7:0]   rx_parity_next;

    // bus state
    logic         wr_pend_reg;
    logic         wr_pend_next;
    logic [7:0]   wr_idx_reg;
    logic [7:0]   wr_idx_next;
    logic [31:0]  hrdata_reg;
    logic [31:0]  hrdata_next;

    // block state
    logic              sig_acc_reg;
    logic              sig_acc_next;
    logic              coll_reg;
    logic              coll_next;
    logic              use_q_reg;
    logic              use_q_next;
    logic              frozen_q_reg;
    logic              frozen_q_next;
    logic              frozen_ok_reg;
    logic              frozen_ok_next;
    logic [TCNT_W-1:0] tcnt_reg;
    logic [TCNT_W-1:0] tcnt_next;
    logic              tick_reg;
    logic              tick_next;
    logic [1:0]        pll_tc_reg;
    logic [1:0]        pll_tc_next;
    logic              pll_frz_reg;
    logic              pll_frz_next;
    logic [3:0]        resp_reg;
    logic [3:0]        resp_next;
    logic              txpar_reg;
    logic              txpar_next;
    logic              par_acc_reg;
    logic              par_acc_next;
    rxd_bit_t          rx_out_reg;
    rxd_bit_t          rx_out_next;
    logic              par_err_reg;
    logic              par_err_next;

    rxd_cfg_t     cfg;
    logic         addr_ok;
    logic         q_stronger;
    logic [TCNT_W-1:0] tcnt_last;
    logic [10:0]  weak_scaled;
    logic [10:0]  strong_scaled;
    logic [7:0]   wbyte;

    // field view of the stored registers
    always_comb
    begin
        cfg.min_signal_threshold      = threshold_reg[MIN_LVL_LSB +: 4];
        cfg.collision_threshold       = threshold_reg[COLL_LVL_LSB +: 3];
        cfg.channel_select_mode       = demod_reg[CH_MODE_LSB +: 2];
        cfg.fixed_channel_enable      = demod_reg[FIX_CH_BIT];
        cfg.even_prescale_select      = demod_reg[EVEN_PS_BIT];
        cfg.pll_receive_time_constant = demod_reg[TAU_RCV_LSB +: 2];
        cfg.pll_burst_time_constant   = demod_reg[TAU_SYNC_LSB +: 2];
        cfg.extra_response_time       = tx_timing_reg[TX_WAIT_LSB +: 2];
        cfg.parity_off                = rx_parity_reg[PAR_OFF_BIT];
    end

    // bus and register next values
    always_comb
    begin
        addr_ok        = hsel && hready && (htrans == HTRANS_NONSEQ);
        wbyte          = hwdata[7:0];
        threshold_next = threshold_reg;
        demod_next     = demod_reg;
        tx_timing_next = tx_timing_reg;
        rx_parity_next = rx_parity_reg;
        wr_pend_next   = addr_ok && hwrite && idx_hit(haddr);
        wr_idx_next    = reg_index(haddr);
        hrdata_next    = hrdata_reg;
        if (wr_pend_reg)
        begin
            case (wr_idx_reg)
                IDX_THRESHOLD: threshold_next = (wbyte & WMASK_THRESHOLD)
                                              | (RST_THRESHOLD & ~WMASK_THRESHOLD); // [RL16]
                IDX_DEMOD:     demod_next     = wbyte & WMASK_DEMOD;
                IDX_TX_TIMING: tx_timing_next = (wbyte & WMASK_TX_TIMING)
                                              | (RST_TX_TIMING & ~WMASK_TX_TIMING); // [RL16]
                IDX_RX_PARITY: rx_parity_next = wbyte & WMASK_RX_PARITY; // [RL16]
                default:       threshold_next = threshold_reg; // [RL16]
            endcase
        end
        if (addr_ok && !hwrite)
        begin
            // read sees a write still in its data phase
            hrdata_next = 32'h0000_0000;
            if (idx_hit(haddr))
            begin
                case (reg_index(haddr))
                    IDX_THRESHOLD: hrdata_next[7:0] = threshold_next;
                    IDX_DEMOD:     hrdata_next[7:0] = demod_next;
                    IDX_TX_TIMING: hrdata_next[7:0] = tx_timing_next;
                    IDX_RX_PARITY: hrdata_next[7:0] = rx_parity_next;
                    default:       hrdata_next[7:0] = RST_RSVD; // [RL15] [RL16]
                endcase
            end
        end
    end

    // decoder, channel, timer, pll and parity next values
    always_comb
    begin
        // signal level and collision
        weak_scaled   = {half_weak, 3'h0};
        strong_scaled = 11'(half_strong) * 11'(cfg.collision_threshold);
        sig_acc_next  = sig_acc_reg;
        coll_next     = coll_reg;
        if (sample_valid)
        begin
            sig_acc_next = (sig_strength >= cfg.min_signal_threshold); // [RL1]
            coll_next    = (sig_strength >= cfg.min_signal_threshold)
                           && (weak_scaled >= strong_scaled); // [RL1] [RL2]
        end

        // channel selection
        q_stronger     = (q_amp > i_amp);
        frozen_q_next  = frozen_q_reg;
        frozen_ok_next = frozen_ok_reg;
        use_q_next     = use_q_reg;
        if (!comm_active)
        begin
            frozen_ok_next = 1'b0;
        end
        else if (!frozen_ok_reg)
        begin
            frozen_ok_next = 1'b1;
            frozen_q_next  = q_stronger;
        end
        if (cfg.fixed_channel_enable)
        begin
            use_q_next = cfg.channel_select_mode[0]; // [RL5]
        end
        else
        begin
            case (cfg.channel_select_mode) // [RL4]
                CH_STRONGER: use_q_next = q_stronger; // [RL3]
                CH_FROZEN:   use_q_next = (comm_active && frozen_ok_reg) ? frozen_q_reg : q_stronger; // [RL3]
                default:     use_q_next = use_q_reg; // [RL3]
            endcase
        end

        // timer prescaler
        tcnt_last = {1'b0, timer_divider_value, 1'b0}
                    + TCNT_W'(cfg.even_prescale_select); // [RL6] [RL7]
        tcnt_next = tcnt_reg;
        tick_next = 1'b0;
        if (carrier_tick)
        begin
            if (tcnt_reg >= tcnt_last)
            begin
                tcnt_next = '0;
                tick_next = 1'b1;
            end
            else
            begin
                tcnt_next = tcnt_reg + TCNT_W'(1);
            end
        end

        // pll time constant
        pll_tc_next  = receiving ? cfg.pll_receive_time_constant
                                 : cfg.pll_burst_time_constant; // [RL8] [RL9]
        pll_frz_next = receiving && (cfg.pll_receive_time_constant == 2'h0); // [RL8]

        // response time and transmit parity
        resp_next  = {2'h0, cfg.extra_response_time} + TX_WAIT_OFFSET; // [RL10]
        txpar_next = !cfg.parity_off; // [RL11]

        // receive parity
        rx_out_next  = '0;
        par_err_next = 1'b0;
        par_acc_next = par_acc_reg;
        if (rx_in.valid)
        begin
            if (rx_in.is_parity && !cfg.parity_off)
            begin
                par_err_next = (rx_in.data == par_acc_reg); // [RL11]
                par_acc_next = 1'b0;
            end
            else
            begin
                rx_out_next.valid = 1'b1;
                rx_out_next.data  = rx_in.data; // [RL12]
                par_acc_next      = rx_in.is_parity ? 1'b0 : (par_acc_reg ^ rx_in.data); // [RL12]
            end
        end
    end

    // registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            threshold_reg <= RST_THRESHOLD; // [RL13]
            demod_reg     <= RST_DEMOD;
            tx_timing_reg <= RST_TX_TIMING; // [RL14]
            rx_parity_reg <= RST_RX_PARITY;
            wr_pend_reg   <= 1'b0;
            wr_idx_reg    <= 8'h00;
            hrdata_reg    <= 32'h0000_0000;
            sig_acc_reg   <= 1'b0;
            coll_reg      <= 1'b0;
            use_q_reg     <= 1'b0;
            frozen_q_reg  <= 1'b0;
            frozen_ok_reg <= 1'b0;
            tcnt_reg      <= '0;
            tick_reg      <= 1'b0;
            pll_tc_reg    <= 2'h0;
            pll_frz_reg   <= 1'b0;
            resp_reg      <= 4'h0;
            txpar_reg     <= 1'b0;
            par_acc_reg   <= 1'b0;
            rx_out_reg    <= '0;
            par_err_reg   <= 1'b0;
        end
        else
        begin
            threshold_reg <= threshold_next;
            demod_reg     <= demod_next;
            tx_timing_reg <= tx_timing_next;
            rx_parity_reg <= rx_parity_next;
            wr_pend_reg   <= wr_pend_next;
            wr_idx_reg    <= wr_idx_next;
            hrdata_reg    <= hrdata_next;
            sig_acc_reg   <= sig_acc_next;
            coll_reg      <= coll_next;
            use_q_reg     <= use_q_next;
            frozen_q_reg  <= frozen_q_next;
            frozen_ok_reg <= frozen_ok_next;
            tcnt_reg      <= tcnt_next;
            tick_reg      <= tick_next;
            pll_tc_reg    <= pll_tc_next;
            pll_frz_reg   <= pll_frz_next;
            resp_reg      <= resp_next;
            txpar_reg     <= txpar_next;
            par_acc_reg   <= par_acc_next;
            rx_out_reg    <= rx_out_next;
            par_err_reg   <= par_err_next;
        end
    end

    // zero wait state from the first clock after reset, always okay response
    logic ready_reg;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ready_reg <= 1'b0;
        end
        else
        begin
            ready_reg <= 1'b1;
        end
    end

    logic resp_err_reg;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            resp_err_reg <= 1'b0;
        end
        else
        begin
            resp_err_reg <= 1'b0;
        end
    end

    assign hrdata              = hrdata_reg;
    assign hreadyout           = ready_reg;
    assign hresp               = resp_err_reg;
    assign sig_accepted        = sig_acc_reg;
    assign bit_collision       = coll_reg;
    assign use_q_channel       = use_q_reg;
    assign timer_tick          = tick_reg;
    assign pll_time_constant   = pll_tc_reg;
    assign pll_frozen          = pll_frz_reg;
    assign extra_response_bits = resp_reg;
    assign tx_parity_enable    = txpar_reg;
    assign rx_out              = rx_out_reg;
    assign rx_parity_error     = par_err_reg;

endmodule

// File: rtl/rxd_pkg.sv
// shared constants and types for the receive decoder configuration block
package rxd_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_THRESHOLD = 8'h18;
    localparam logic [7:0] IDX_DEMOD     = 8'h19;
    localparam logic [7:0] IDX_RSVD_A    = 8'h1a;
    localparam logic [7:0] IDX_RSVD_B    = 8'h1b;
    localparam logic [7:0] IDX_TX_TIMING = 8'h1c;
    localparam logic [7:0] IDX_RX_PARITY = 8'h1d;
    localparam int         ADDR_SHIFT    = 2;

    // reset values
    localparam logic [7:0] RST_THRESHOLD = 8'h84;
    localparam logic [7:0] RST_DEMOD     = 8'h4d;
    localparam logic [7:0] RST_RSVD      = 8'h00;
    localparam logic [7:0] RST_TX_TIMING = 8'h62;
    localparam logic [7:0] RST_RX_PARITY = 8'h00;

    // writable bits of each register
    localparam logic [7:0] WMASK_THRESHOLD = 8'hf7;
    localparam logic [7:0] WMASK_DEMOD     = 8'hff;
    localparam logic [7:0] WMASK_TX_TIMING = 8'h03;
    localparam logic [7:0] WMASK_RX_PARITY = 8'h10;

    // field positions
    localparam int MIN_LVL_LSB  = 4;
    localparam int COLL_LVL_LSB = 0;
    localparam int CH_MODE_LSB  = 6;
    localparam int FIX_CH_BIT   = 5;
    localparam int EVEN_PS_BIT  = 4;
    localparam int TAU_RCV_LSB  = 2;
    localparam int TAU_SYNC_LSB = 0;
    localparam int TX_WAIT_LSB  = 0;
    localparam int PAR_OFF_BIT  = 4;

    // channel select codes
    localparam logic [1:0] CH_STRONGER = 2'h0;
    localparam logic [1:0] CH_FROZEN   = 2'h1;

    // response time offset in bit periods
    localparam logic [3:0] TX_WAIT_OFFSET = 4'h7;

    // collision threshold scale: level counts eighths of the stronger half-bit
    localparam int COLL_SCALE_SHIFT = 3;

    // ahb transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // decoded configuration fields
    typedef struct packed {
        logic [3:0] min_signal_threshold;
        logic [2:0] collision_threshold;
        logic [1:0] channel_select_mode;
        logic       fixed_channel_enable;
        logic       even_prescale_select;
        logic [1:0] pll_receive_time_constant;
        logic [1:0] pll_burst_time_constant;
        logic [1:0] extra_response_time;
        logic       parity_off;
    } rxd_cfg_t;

    // received bit stream
    typedef struct packed {
        logic valid;
        logic data;
        logic is_parity;
    } rxd_bit_t;

endpackage
